// >>> hw/dll_pll_clock_config.v
// clock configuration and delay-loop status registers behind the serial register port
// assumes: loop status inputs come from the analog delay loop, synchronous to ref_clk
`timescale 1ns/1ps
`include "dll_pll_clock_config_defines.vh"

module dll_pll_clock_config (
  input  wire       ref_clk,                  // 50 MHz system clock
  input  wire       nrst,                     // synchronous reset, active low
  input  wire       sclk,                     // serial port clock
  input  wire       csb_n,                    // serial port select, active low
  input  wire       sdio_in,                  // serial data pin, input side
  output wire       sdio_out,                 // serial data pin, output side
  output wire       sdio_oe_n,                // serial data pin enable, low while driving
  input  wire       dll_locked,               // delay loop lock level
  input  wire       dll_near_edge,            // delay loop near either delay-line end
  input  wire       dll_at_start,             // delay loop at start of delay line
  input  wire       dll_at_end,               // delay loop at end of delay line
  input  wire       data_clock_present,       // data clock input above 100 MHz detected
  input  wire       delay_loop_tracking,      // closed loop attempting to lock
  input  wire [5:0] auto_band,                // band chosen by automatic calibration
  output reg        conv_clock_duty_fix_en,   // conversion clock duty correction
  output reg        conv_clock_xpoint_en,     // conversion clock crosspoint control
  output reg  [4:0] conv_clock_xpoint_level,  // conversion clock crosspoint level
  output reg        ref_clock_duty_fix_en,    // reference clock duty correction
  output reg        ref_clock_xpoint_en,      // reference clock crosspoint control
  output reg  [4:0] ref_clock_xpoint_level,   // reference clock crosspoint level
  output reg        multiplier_enable,        // multiplier power/enable
  output reg        band_manual_sel,          // one = manual band selection
  output reg  [5:0] vco_band,                 // band in effect
  output reg  [2:0] loop_filter_bandwidth,    // loop filter bandwidth code
  output reg  [4:0] charge_pump_current,      // charge pump current code
  output reg  [7:0] divider_control           // stored multiplier divider byte
);

  reg  [7:0] data_ctrl1_q;
  reg  [7:0] status_q;
  reg  [7:0] conv_rx_q;
  reg  [7:0] ref_rx_q;
  reg  [7:0] main_ctrl_q;
  reg  [7:0] loop_tune_q;
  reg  [7:0] div_ctrl_q;
  reg  [7:0] rdata_q;
  reg  [2:0] warn_d;

  wire       wr_pulse;
  wire       rd_pulse;
  wire [6:0] addr;
  wire [7:0] wdata;
  wire       clear_warn;

  serial_reg_port u_port (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .sclk      (sclk),
    .csb_n     (csb_n),
    .sdio_in   (sdio_in),
    .sdio_out  (sdio_out),
    .sdio_oe_n (sdio_oe_n),
    .wr_pulse  (wr_pulse),
    .rd_pulse  (rd_pulse),
    .addr      (addr),
    .wdata     (wdata),
    .rdata     (rdata_q)
  );

  assign clear_warn = wr_pulse && addr == `ADDR_DATA_CTRL1 && wdata[`CLEAR_WARN_BIT];

  // sticky warnings: an event in the clearing cycle survives the clear
  always @* begin
    warn_d = clear_warn ? 3'h0 : status_q[`ST_WARN_BIT:`ST_END_BIT];
    warn_d = warn_d | {dll_near_edge, dll_at_start, dll_at_end};
  end

  // software-written registers
  always @(posedge ref_clk) begin
    if (!nrst) begin
      data_ctrl1_q <= `RST_DATA_CTRL1;
      conv_rx_q    <= `RST_CONV_CLK_RX_CTRL;
      ref_rx_q     <= `RST_REF_CLK_RX_CTRL;
      main_ctrl_q  <= `RST_MULT_MAIN_CTRL;
      loop_tune_q  <= `RST_MULT_LOOP_TUNING;
      div_ctrl_q   <= `RST_MULT_DIVIDER_CTRL;
    end else if (wr_pulse) begin
      case (addr)
        `ADDR_DATA_CTRL1:        data_ctrl1_q <= {1'b0, wdata[6:0]};
        `ADDR_CONV_CLK_RX_CTRL:  conv_rx_q    <= wdata;
        `ADDR_REF_CLK_RX_CTRL:   ref_rx_q     <= wdata;
        `ADDR_MULT_MAIN_CTRL:    main_ctrl_q  <= wdata;
        `ADDR_MULT_LOOP_TUNING:  loop_tune_q  <= wdata;
        `ADDR_MULT_DIVIDER_CTRL: div_ctrl_q   <= wdata;
        default:                 data_ctrl1_q <= data_ctrl1_q;
      endcase
    end
  end

  // status register: never written by software
  always @(posedge ref_clk) begin
    if (!nrst) begin
      status_q <= `RST_DATA_RX_STATUS;
    end else begin
      status_q[`ST_LOCK_BIT]               <= dll_locked;
      status_q[`ST_WARN_BIT]               <= warn_d[2];
      status_q[`ST_START_BIT]              <= warn_d[1];
      status_q[`ST_END_BIT]                <= warn_d[0];
      status_q[3]                          <= 1'b0;
      status_q[`ST_CLK_PRESENT_BIT]        <= data_clock_present;
      status_q[1]                          <= 1'b0;
      status_q[`ST_TRACKING_BIT]           <= delay_loop_tracking;
    end
  end

  // read data, one cycle after the read strobe; unmapped reads return zero
  always @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (rd_pulse) begin
      case (addr)
        `ADDR_DATA_CTRL1:        rdata_q <= data_ctrl1_q;
        `ADDR_DATA_RX_STATUS:    rdata_q <= status_q;
        `ADDR_CONV_CLK_RX_CTRL:  rdata_q <= conv_rx_q;
        `ADDR_REF_CLK_RX_CTRL:   rdata_q <= ref_rx_q;
        `ADDR_MULT_MAIN_CTRL:    rdata_q <= main_ctrl_q;
        `ADDR_MULT_LOOP_TUNING:  rdata_q <= loop_tune_q;
        `ADDR_MULT_DIVIDER_CTRL: rdata_q <= div_ctrl_q;
        default:                 rdata_q <= 8'h00;
      endcase
    end
  end

  // field outputs, each a flip-flop trailing its register by one cycle; vco_band in automatic mode trails auto_band instead
  always @(posedge ref_clk) begin
    if (!nrst) begin
      conv_clock_duty_fix_en  <= 1'b0;
      conv_clock_xpoint_en    <= 1'b0;
      conv_clock_xpoint_level <= 5'h00;
      ref_clock_duty_fix_en   <= 1'b0;
      ref_clock_xpoint_en     <= 1'b0;
      ref_clock_xpoint_level  <= 5'h00;
      multiplier_enable       <= 1'b0;
      band_manual_sel         <= 1'b0;
      vco_band                <= 6'h00;
      loop_filter_bandwidth   <= 3'h0;
      charge_pump_current     <= 5'h00;
      divider_control         <= 8'h00;
    end else begin
      conv_clock_duty_fix_en  <= conv_rx_q[`RX_DUTY_FIX_BIT];
      conv_clock_xpoint_en    <= conv_rx_q[`RX_XPOINT_EN_BIT];
      conv_clock_xpoint_level <= conv_rx_q[`RX_XPOINT_LVL_MSB:`RX_XPOINT_LVL_LSB];
      ref_clock_duty_fix_en   <= ref_rx_q[`RX_DUTY_FIX_BIT];
      ref_clock_xpoint_en     <= ref_rx_q[`RX_XPOINT_EN_BIT];
      ref_clock_xpoint_level  <= ref_rx_q[`RX_XPOINT_LVL_MSB:`RX_XPOINT_LVL_LSB];
      multiplier_enable       <= main_ctrl_q[`MULT_ENABLE_BIT];
      band_manual_sel         <= main_ctrl_q[`MULT_MANUAL_BIT];
      vco_band                <= main_ctrl_q[`MULT_MANUAL_BIT] ?
                                 main_ctrl_q[`MULT_BAND_MSB:`MULT_BAND_LSB] : auto_band;
      loop_filter_bandwidth   <= loop_tune_q[`MULT_BW_MSB:`MULT_BW_LSB];
      charge_pump_current     <= loop_tune_q[`MULT_CP_MSB:`MULT_CP_LSB];
      divider_control         <= div_ctrl_q;
    end
  end

endmodule // dll_pll_clock_config

// >>> hw/dll_pll_clock_config_defines.vh
// register offsets, field positions, reset values and serial framing for the clock configuration block
// assumes: included by bare name from the design files of this block
`ifndef DLL_PLL_CLOCK_CONFIG_DEFINES_VH
`define DLL_PLL_CLOCK_CONFIG_DEFINES_VH

// register offsets (7-bit serial address)
`define ADDR_DATA_CTRL1          7'h0B
`define ADDR_DATA_RX_STATUS      7'h0E
`define ADDR_CONV_CLK_RX_CTRL    7'h10
`define ADDR_REF_CLK_RX_CTRL     7'h11
`define ADDR_MULT_MAIN_CTRL      7'h12
`define ADDR_MULT_LOOP_TUNING    7'h14
`define ADDR_MULT_DIVIDER_CTRL   7'h15

// reset values
`define RST_DATA_CTRL1           8'h39
`define RST_DATA_RX_STATUS       8'h00
`define RST_CONV_CLK_RX_CTRL     8'hFF
`define RST_REF_CLK_RX_CTRL      8'h5F
`define RST_MULT_MAIN_CTRL       8'h00
`define RST_MULT_LOOP_TUNING     8'hE7
`define RST_MULT_DIVIDER_CTRL    8'hC9

// status register bit positions
`define ST_LOCK_BIT              7
`define ST_WARN_BIT              6
`define ST_START_BIT             5
`define ST_END_BIT               4
`define ST_CLK_PRESENT_BIT       2
`define ST_TRACKING_BIT          0

// data control 1: clear-warning strobe
`define CLEAR_WARN_BIT           7

// receiver control fields
`define RX_DUTY_FIX_BIT          7
`define RX_RESERVED_BIT          6
`define RX_XPOINT_EN_BIT         5
`define RX_XPOINT_LVL_MSB        4
`define RX_XPOINT_LVL_LSB        0

// multiplier main control fields
`define MULT_ENABLE_BIT          7
`define MULT_MANUAL_BIT          6
`define MULT_BAND_MSB            5
`define MULT_BAND_LSB            0

// multiplier loop tuning fields
`define MULT_BW_MSB              7
`define MULT_BW_LSB              5
`define MULT_CP_MSB              4
`define MULT_CP_LSB              0

// serial framing: read/write flag, 7 address bits, 8 data bits
`define SER_INSTR_BITS           5'h08
`define SER_FRAME_BITS           5'h10

`endif

// >>> hw/serial_reg_port.v
// serial register port: 3-wire slave, sclk/csb/sdio sampled on ref_clk
// assumes: pins synchronous to ref_clk, sclk high and low each at least 4 ref_clk periods
`timescale 1ns/1ps
`include "dll_pll_clock_config_defines.vh"

module serial_reg_port (
  input  wire       ref_clk,      // system clock
  input  wire       nrst,         // synchronous reset, active low
  input  wire       sclk,         // serial clock pin level
  input  wire       csb_n,        // chip select, active low
  input  wire       sdio_in,      // data pin, input side
  output reg        sdio_out,     // data pin, output side
  output reg        sdio_oe_n,    // data pin enable, low while driving
  output reg        wr_pulse,     // one-cycle register write strobe
  output reg        rd_pulse,     // one-cycle register read strobe
  output reg  [6:0] addr,         // register address
  output reg  [7:0] wdata,        // register write data
  input  wire [7:0] rdata         // register read data, valid 1 cycle after rd_pulse
);

  reg        sclk_q;
  reg  [4:0] cnt_q;
  reg  [6:0] sh_q;
  reg        rd_mode_q;
  reg  [7:0] out_q;
  wire       rise = sclk & ~sclk_q;
  wire       fall = ~sclk & sclk_q;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      sclk_q    <= 1'b0;
      cnt_q     <= 5'h00;
      sh_q      <= 7'h00;
      rd_mode_q <= 1'b0;
      out_q     <= 8'h00;
      sdio_out  <= 1'b0;
      sdio_oe_n <= 1'b1;
      wr_pulse  <= 1'b0;
      rd_pulse  <= 1'b0;
      addr      <= 7'h00;
      wdata     <= 8'h00;
    end else begin
      sclk_q   <= sclk;
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      if (csb_n) begin
        cnt_q     <= 5'h00;
        rd_mode_q <= 1'b0;
        sdio_oe_n <= 1'b1;
      end else begin
        if (rise && cnt_q < `SER_FRAME_BITS) begin
          sh_q  <= {sh_q[5:0], sdio_in};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == `SER_INSTR_BITS - 5'h01) begin
            addr <= {sh_q[5:0], sdio_in};
            if (sh_q[6]) begin
              rd_pulse  <= 1'b1;
              rd_mode_q <= 1'b1;
            end
          end
          if (cnt_q == `SER_FRAME_BITS - 5'h01 && !rd_mode_q) begin
            wr_pulse <= 1'b1;
            wdata    <= {sh_q[6:0], sdio_in};
          end
        end
        // read data leaves msb first, one bit per falling edge
        if (fall && rd_mode_q) begin
          if (sdio_oe_n) begin
            sdio_out  <= rdata[7];
            out_q     <= {rdata[6:0], 1'b0};
            sdio_oe_n <= 1'b0;
          end else begin
            sdio_out <= out_q[7];
            out_q    <= {out_q[6:0], 1'b0};
          end
        end
      end
    end
  end

endmodule // serial_reg_port

// >>> testbench/dll_pll_clock_config_props.sv
// checker: port-level properties of the clock configuration block
// assumes: bound to dll_pll_clock_config, one clock domain with synchronous active-low reset
`timescale 1ns/1ps
module dll_pll_clock_config_props (
  input wire       ref_clk,                  // clock
  input wire       nrst,                     // reset, active low
  input wire       sclk,                     // serial clock
  input wire       csb_n,                    // serial select
  input wire       sdio_out,                 // serial data out
  input wire       sdio_oe_n,                // data pin enable
  input wire [5:0] auto_band,                // calibrated band
  input wire       conv_clock_duty_fix_en,   // conv duty fix
  input wire       conv_clock_xpoint_en,     // conv crosspoint enable
  input wire [4:0] conv_clock_xpoint_level,  // conv crosspoint level
  input wire       ref_clock_duty_fix_en,    // ref duty fix
  input wire       ref_clock_xpoint_en,      // ref crosspoint enable
  input wire [4:0] ref_clock_xpoint_level,   // ref crosspoint level
  input wire       multiplier_enable,        // multiplier on
  input wire       band_manual_sel,          // manual band mode
  input wire [5:0] vco_band,                 // band in effect
  input wire [2:0] loop_filter_bandwidth,    // loop bandwidth
  input wire [4:0] charge_pump_current,      // pump current
  input wire [7:0] divider_control           // divider byte
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_rel;
    $rose(nrst);
  endsequence
  sequence s_idle;
    csb_n [*3];
  endsequence
  sequence s_auto;
    (!band_manual_sel && $stable(auto_band)) [*3];
  endsequence

  AST_CONV_RST: assert property (s_rel |=> conv_clock_duty_fix_en && conv_clock_xpoint_en)
    else $error("conv receiver enables wrong after reset");
  AST_XLVL_RST: assert property (s_rel |=> conv_clock_xpoint_level == 5'h1F &&
    ref_clock_xpoint_level == 5'h1F)
    else $error("crosspoint levels wrong after reset");
  AST_REF_RST: assert property (s_rel |=> !ref_clock_duty_fix_en && !ref_clock_xpoint_en)
    else $error("ref receiver enables wrong after reset");
  AST_MULT_RST: assert property (s_rel |=> !multiplier_enable && !band_manual_sel)
    else $error("multiplier control wrong after reset");
  AST_TUNE_RST: assert property (s_rel |=> loop_filter_bandwidth == 3'h7 && charge_pump_current == 5'h07)
    else $error("loop tuning wrong after reset");
  AST_AUTO_BAND: assert property (s_auto |-> vco_band == auto_band)
    else $error("automatic band not followed");
  AST_IDLE_OE: assert property (s_idle |-> sdio_oe_n)
    else $error("data pin driven while deselected");
  AST_DRIVE: assert property ($fell(sdio_oe_n) |-> !csb_n && !sclk)
    else $error("data pin driven outside read phase");
  AST_BIT_HOLD: assert property (!sdio_oe_n && $past(!sdio_oe_n) && $past(sclk) && $past(sclk, 2) |->
    $stable(sdio_out))
    else $error("read bit changed without falling serial clock");
  // frame gaps are three cycles long, so a settled write is watched in every gap
  AST_HOLD: assert property (s_idle |-> $stable({conv_clock_duty_fix_en, conv_clock_xpoint_en,
    conv_clock_xpoint_level, ref_clock_duty_fix_en, ref_clock_xpoint_en, ref_clock_xpoint_level, divider_control,
    multiplier_enable, band_manual_sel, charge_pump_current, loop_filter_bandwidth}))
    else $error("control output changed without a frame");
endmodule // dll_pll_clock_config_props

// >>> testbench/tb_dll_pll_clock_config.sv
// testbench: serial register access, status capture and control field ports
// assumes: design sources and checker compiled before this file
`timescale 1ns/1ps
module tb_dll_pll_clock_config;
  logic       ref_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       sclk = 1'b0;
  logic       csb_n = 1'b1;
  logic       sdio_drv = 1'b0;
  logic [5:0] st = 6'h00;
  logic [5:0] auto_band = 6'h00;
  logic [2:0] stw;
  logic [7:0] q, d;
  logic [6:0] a;
  int         failures = 0, checks_done = 0, cycles = 0;
  logic [6:0] regs [5] = '{7'h10, 7'h11, 7'h12, 7'h14, 7'h15};
  logic [7:0] rstv [5] = '{8'hFF, 8'h5F, 8'h00, 8'hE7, 8'hC9};
  logic [7:0] crn [10] = '{8'hCF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h40, 8'h40, 8'hC0, 8'hFF, 8'hFF};
  wire        sdio_out, sdio_oe_n, cd, cx, rdf, rx, me, bm;
  wire  [4:0] cl, rl, cp;
  wire  [5:0] vb;
  wire  [2:0] bw;
  wire  [7:0] dv;
  wire        sdio_in = sdio_oe_n ? sdio_drv : sdio_out;

  dll_pll_clock_config i_dll_pll_clock_config (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .csb_n(csb_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .dll_locked(st[5]), .dll_near_edge(st[4]),
    .dll_at_start(st[3]), .dll_at_end(st[2]), .data_clock_present(st[1]), .delay_loop_tracking(st[0]),
    .auto_band(auto_band), .conv_clock_duty_fix_en(cd), .conv_clock_xpoint_en(cx), .conv_clock_xpoint_level(cl),
    .ref_clock_duty_fix_en(rdf), .ref_clock_xpoint_en(rx), .ref_clock_xpoint_level(rl), .multiplier_enable(me),
    .band_manual_sel(bm), .vco_band(vb), .loop_filter_bandwidth(bw), .charge_pump_current(cp), .divider_control(dv));

  always #10 ref_clk = ~ref_clk;

  // one 16-bit frame, data bits sampled at the end of each low phase
  task automatic frame(input logic rw, input logic [6:0] ad, input logic [7:0] wd, output logic [7:0] rq);
    logic [15:0] w;
    w = {rw, ad, wd};
    csb_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      sdio_drv = w[i];
      repeat (5) @(posedge ref_clk);
      #1;
      if (i < 8) rq[i] = sdio_out;
      sclk = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
    end
    csb_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd_chk(input string n, input logic [6:0] ad, input logic [7:0] e);
    logic [7:0] rq;
    frame(1'b1, ad, 8'h00, rq);
    chk(n, e, rq);
  endtask

  function automatic logic [7:0] stat(input logic [5:0] s);
    return {s[5:2], 1'b0, s[1], 1'b0, s[0]};
  endfunction

  function automatic logic [7:0] expv(input logic [6:0] ad, input logic [7:0] v);
    if (ad == 7'h10 || ad == 7'h11) return {1'b0, v[7], v[5:0]};
    if (ad == 7'h12) return {v[7:6], v[6] ? v[5:0] : auto_band};
    return v;
  endfunction

  function automatic logic [7:0] view(input logic [6:0] ad);
    case (ad)
      7'h10: return {1'b0, cd, cx, cl};
      7'h11: return {1'b0, rdf, rx, rl};
      7'h12: return {me, bm, vb};
      7'h14: return {bw, cp};
      default: return dv;
    endcase
  endfunction

  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("unexpected run length: expected below 40000 seen 40000");
      end_sim();
    end
  end

  initial begin
    q = 8'($urandom(32'h1F596466));
    repeat (10) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 5; i++) begin
      rd_chk("reset value", regs[i], rstv[i]);
      chk("reset port", expv(regs[i], rstv[i]), view(regs[i]));
    end
    rd_chk("status reset", 7'h0E, 8'h00);
    rd_chk("unmapped", 7'h13, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      st = 6'h00;
      frame(1'b0, 7'h0B, 8'hB9, q);
      st = (i == 0) ? 6'h3F : ((i == 1) ? 6'h00 : 6'($urandom));
      stw = st[4:2];
      rd_chk("status", 7'h0E, stat(st));
      frame(1'b0, 7'h0E, 8'($urandom), q);
      st = st & 6'h23;
      rd_chk("sticky", 7'h0E, stat(st) | {1'b0, stw, 4'h0});
      frame(1'b0, 7'h0B, 8'hB9, q);
      rd_chk("cleared", 7'h0E, stat(st));
    end
    rd_chk("clear strobe", 7'h0B, 8'h39);
    $display("test status done");
    for (int i = 0; i < 30; i++) begin
      a = regs[i % 5];
      d = (i < 10) ? crn[i] : 8'($urandom);
      if (a == 7'h10 || a == 7'h11) d[6] = 1'b1;
      auto_band = 6'($urandom);
      frame(1'b0, a, d, q);
      rd_chk("readback", a, d);
      chk("field port", expv(a, d), view(a));
    end
    $display("test control done");
    end_sim();
  end
endmodule // tb_dll_pll_clock_config

bind dll_pll_clock_config dll_pll_clock_config_props i_dll_pll_clock_config_props (.ref_clk(ref_clk), .nrst(nrst),
  .sclk(sclk), .csb_n(csb_n), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .auto_band(auto_band),
  .conv_clock_duty_fix_en(conv_clock_duty_fix_en), .conv_clock_xpoint_en(conv_clock_xpoint_en),
  .conv_clock_xpoint_level(conv_clock_xpoint_level), .ref_clock_duty_fix_en(ref_clock_duty_fix_en),
  .ref_clock_xpoint_en(ref_clock_xpoint_en), .ref_clock_xpoint_level(ref_clock_xpoint_level),
  .multiplier_enable(multiplier_enable), .band_manual_sel(band_manual_sel), .vco_band(vco_band),
  .loop_filter_bandwidth(loop_filter_bandwidth), .charge_pump_current(charge_pump_current),
  .divider_control(divider_control));
